// ==== src/acc_core.sv ====
// comparator control register, pin and event logic
module acc_core
    import acc_pkg::*;
(
    input wire logic clk,
    input wire logic resetn,
    input wire logic [7:0] addr,
    input wire logic [31:0] wdata,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic [31:0] rdata,
    input wire logic comparator_raw,
    output logic comparator_enable,
    output logic plus_input_select,
    output acc_minus_e minus_input_select,
    output logic result_output_pin,
    output logic result_output_pin_oe,
    output logic event_pulse
);
    acc_state_s state_reg;
    acc_state_s state_next;
    logic polar;
    logic write_hit;
    logic read_hit;
    logic event_now;
    logic enable_next;
    logic drive_next;
    logic invert_next;
    logic [1:0] edge_next;
    logic plus_next;
    logic [1:0] minus_next;
    logic [31:0] enable_word;
    logic [31:0] drive_word;
    logic [31:0] invert_word;
    logic [31:0] live_word;
    logic [31:0] edge_word;
    logic [31:0] plus_word;
    logic [31:0] minus_word;
    logic [31:0] read_word;

    // only the control word is mapped
    acc_reg_decode acc_reg_decode_i (
        .addr(addr),
        .wr_en(wr_en),
        .rd_en(rd_en),
        .write_hit(write_hit),
        .read_hit(read_hit)
    );

    // synchronised result after optional inversion
    acc_polarity acc_polarity_i (
        .synced(state_reg.sync2),
        .invert(state_reg.ctrl.result_invert),
        .polar(polar)
    );

    // next field values; other bits of a write are dropped
    acc_field_update #(.LSB(ACC_ON_BIT), .WIDTH(1)) enable_update_i (
        .wdata(wdata),
        .write_hit(write_hit),
        .current(state_reg.ctrl.enable),
        .updated(enable_next)
    );

    acc_field_update #(.LSB(ACC_OE_BIT), .WIDTH(1)) drive_update_i (
        .wdata(wdata),
        .write_hit(write_hit),
        .current(state_reg.ctrl.result_pin_drive_enable),
        .updated(drive_next)
    );

    acc_field_update #(.LSB(ACC_POL_BIT), .WIDTH(1)) invert_update_i (
        .wdata(wdata),
        .write_hit(write_hit),
        .current(state_reg.ctrl.result_invert),
        .updated(invert_next)
    );

    acc_field_update #(.LSB(ACC_EDGE_LSB), .WIDTH(2)) edge_update_i (
        .wdata(wdata),
        .write_hit(write_hit),
        .current(state_reg.ctrl.event_edge_select),
        .updated(edge_next)
    );

    acc_field_update #(.LSB(ACC_PLUS_BIT), .WIDTH(1)) plus_update_i (
        .wdata(wdata),
        .write_hit(write_hit),
        .current(state_reg.ctrl.plus_input_select),
        .updated(plus_next)
    );

    acc_field_update #(.LSB(ACC_MINUS_LSB), .WIDTH(2)) minus_update_i (
        .wdata(wdata),
        .write_hit(write_hit),
        .current(state_reg.ctrl.minus_input_select),
        .updated(minus_next)
    );

    // each field in its place in the read word
    acc_field_place #(.LSB(ACC_ON_BIT), .WIDTH(1)) enable_place_i (
        .value(state_reg.ctrl.enable),
        .word(enable_word)
    );

    acc_field_place #(.LSB(ACC_OE_BIT), .WIDTH(1)) drive_place_i (
        .value(state_reg.ctrl.result_pin_drive_enable),
        .word(drive_word)
    );

    acc_field_place #(.LSB(ACC_POL_BIT), .WIDTH(1)) invert_place_i (
        .value(state_reg.ctrl.result_invert),
        .word(invert_word)
    );

    acc_field_place #(.LSB(ACC_LIVE_BIT), .WIDTH(1)) live_place_i (
        .value(polar),
        .word(live_word)
    );

    acc_field_place #(.LSB(ACC_EDGE_LSB), .WIDTH(2)) edge_place_i (
        .value(state_reg.ctrl.event_edge_select),
        .word(edge_word)
    );

    acc_field_place #(.LSB(ACC_PLUS_BIT), .WIDTH(1)) plus_place_i (
        .value(state_reg.ctrl.plus_input_select),
        .word(plus_word)
    );

    acc_field_place #(.LSB(ACC_MINUS_LSB), .WIDTH(2)) minus_place_i (
        .value(state_reg.ctrl.minus_input_select),
        .word(minus_word)
    );

    // event decision on the inverted or plain result
    acc_edge_event acc_edge_event_i (
        .enable(state_reg.ctrl.enable),
        .edge_select(state_reg.ctrl.event_edge_select),
        .polar_now(polar),
        .polar_before(state_reg.prev),
        .pulse(event_now)
    );

    // unmapped bits stay zero in the merged word
    acc_read_merge acc_read_merge_i (
        .read_hit(read_hit),
        .enable_word(enable_word),
        .drive_word(drive_word),
        .invert_word(invert_word),
        .live_word(live_word),
        .edge_word(edge_word),
        .plus_word(plus_word),
        .minus_word(minus_word),
        .read_word(read_word)
    );

    always_comb begin
        state_next = state_reg;
        state_next.sync1 = comparator_raw;
        state_next.sync2 = state_reg.sync1;
        state_next.prev = polar;
        state_next.event_pulse = event_now;
        state_next.ctrl.enable = enable_next;
        state_next.ctrl.result_pin_drive_enable = drive_next;
        state_next.ctrl.result_invert = invert_next;
        state_next.ctrl.event_edge_select = acc_edge_e'(edge_next);
        state_next.ctrl.plus_input_select = plus_next;
        state_next.ctrl.minus_input_select = acc_minus_e'(minus_next);
        state_next.rdata = read_word;
    end

    always_ff @(posedge clk) begin
        if (!resetn) begin
            state_reg <= '0;
            state_reg.ctrl.event_edge_select <= acc_edge_e'(ACC_EDGE_RST);
            state_reg.ctrl.minus_input_select <= acc_minus_e'(ACC_MINUS_RST);
        end else begin
            state_reg <= state_next;
        end
    end

    assign rdata = state_reg.rdata;
    assign comparator_enable = state_reg.ctrl.enable;
    assign plus_input_select = state_reg.ctrl.plus_input_select;
    assign minus_input_select = state_reg.ctrl.minus_input_select;
    assign result_output_pin = state_reg.prev;
    assign result_output_pin_oe = state_reg.ctrl.result_pin_drive_enable;
    assign event_pulse = state_reg.event_pulse;
endmodule

// one control field: next value from a register write
module acc_field_update
    import acc_pkg::*;
#(
    parameter int LSB = 0,
    parameter int WIDTH = 1
)
(
    input wire logic [31:0] wdata,
    input wire logic write_hit,
    input wire logic [WIDTH-1:0] current,
    output logic [WIDTH-1:0] updated
);
    always_comb begin
        updated = current;
        if (write_hit) begin
            updated = wdata[LSB +: WIDTH];
        end
    end
endmodule

// one control field: its place in the read word
module acc_field_place
    import acc_pkg::*;
#(
    parameter int LSB = 0,
    parameter int WIDTH = 1
)
(
    input wire logic [WIDTH-1:0] value,
    output logic [31:0] word
);
    always_comb begin
        word = 32'h00000000;
        word[LSB +: WIDTH] = value;
    end
endmodule

// event pulse from the chosen edge of the result
module acc_edge_event
    import acc_pkg::*;
(
    input wire logic enable,
    input wire acc_edge_e edge_select,
    input wire logic polar_now,
    input wire logic polar_before,
    output logic pulse
);
    logic rising;
    logic falling;

    always_comb begin
        rising = polar_now & ~polar_before;
        falling = ~polar_now & polar_before;
        pulse = 1'h0;
        if (enable) begin
            unique case (edge_select)
                ACC_EDGE_NONE: pulse = 1'h0;
                ACC_EDGE_RISE: pulse = rising;
                ACC_EDGE_FALL: pulse = falling;
                ACC_EDGE_BOTH: pulse = rising | falling;
            endcase
        end
    end
endmodule

// register strobes against the one mapped offset
module acc_reg_decode
    import acc_pkg::*;
(
    input wire logic [7:0] addr,
    input wire logic wr_en,
    input wire logic rd_en,
    output logic write_hit,
    output logic read_hit
);
    always_comb begin
        write_hit = wr_en && (addr == ACC_CTRL_OFS);
        read_hit = rd_en && (addr == ACC_CTRL_OFS);
    end
endmodule

// optional inversion of the synchronised result
module acc_polarity
    import acc_pkg::*;
(
    input wire logic synced,
    input wire logic invert,
    output logic polar
);
    always_comb begin
        polar = synced ^ invert;
    end
endmodule

// read word: fields merged, zero outside a read
module acc_read_merge
    import acc_pkg::*;
(
    input wire logic read_hit,
    input wire logic [31:0] enable_word,
    input wire logic [31:0] drive_word,
    input wire logic [31:0] invert_word,
    input wire logic [31:0] live_word,
    input wire logic [31:0] edge_word,
    input wire logic [31:0] plus_word,
    input wire logic [31:0] minus_word,
    output logic [31:0] read_word
);
    always_comb begin
        read_word = 32'h00000000;
        if (read_hit) begin
            read_word = enable_word | drive_word | invert_word | live_word | edge_word
                | plus_word | minus_word;
        end
    end
endmodule

// ==== src/acc_pkg.sv ====
// package for the comparator control block
package acc_pkg;
    // register offset of the control word (byte address)
    localparam logic [7:0] ACC_CTRL_OFS = 8'h00;
    localparam int ACC_ON_BIT = 15;
    localparam int ACC_OE_BIT = 14;
    localparam int ACC_POL_BIT = 13;
    localparam int ACC_LIVE_BIT = 8;
    localparam int ACC_EDGE_LSB = 6;
    localparam int ACC_PLUS_BIT = 4;
    localparam int ACC_MINUS_LSB = 0;
    // reset values
    localparam logic [1:0] ACC_EDGE_RST = 2'h3;
    localparam logic [1:0] ACC_MINUS_RST = 2'h3;

    typedef enum logic [1:0] {
        ACC_EDGE_NONE = 2'b00,
        ACC_EDGE_RISE = 2'b01,
        ACC_EDGE_FALL = 2'b10,
        ACC_EDGE_BOTH = 2'b11
    } acc_edge_e;

    typedef enum logic [1:0] {
        ACC_MINUS_B = 2'b00,
        ACC_MINUS_C = 2'b01,
        ACC_MINUS_D = 2'b10,
        ACC_MINUS_BANDGAP = 2'b11
    } acc_minus_e;

    typedef struct packed {
        logic enable;
        logic result_pin_drive_enable;
        logic result_invert;
        acc_edge_e event_edge_select;
        logic plus_input_select;
        acc_minus_e minus_input_select;
    } acc_ctrl_s;

    typedef struct packed {
        acc_ctrl_s ctrl;
        logic sync1;
        logic sync2;
        logic prev;
        logic event_pulse;
        logic [31:0] rdata;
    } acc_state_s;
endpackage

// ==== tb/acc_core_asserts.sv ====
// checker for the comparator control block
module acc_core_asserts (
    input wire logic clk,
    input wire logic resetn,
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic event_pulse,
    input wire logic comparator_enable,
    input wire logic result_output_pin,
    input wire logic result_output_pin_oe,
    input wire logic [7:0] addr,
    input wire logic [31:0] rdata
);
    timeunit 1ns;
    timeprecision 100ps;
    default clocking @(posedge clk); endclocking
    default disable iff (!resetn);
    a_rd_idle: assert property (!$past(rd_en) |-> !rdata) else $error("rdata idle");
    a_rd_rsvd: assert property ($past(rd_en) |-> !(rdata & 32'hFFFF1E2C))
        else $error("rsvd bits");
    a_rd_unmap: assert property (rd_en && addr |=> !rdata) else $error("unmapped rd");
    a_wr_unmap: assert property (wr_en && addr |=> $stable(result_output_pin_oe))
        else $error("unmapped wr");
    a_en_hold: assert property (!wr_en |=> $stable(comparator_enable)) else $error("en");
    a_oe_hold: assert property (!wr_en |=> $stable(result_output_pin_oe)) else $error("oe");
    a_pulse_one: assert property (event_pulse |-> $changed(result_output_pin)) else $error("pulse");
    a_rst_vals: assert property (!$past(resetn) |-> !comparator_enable && !event_pulse)
        else $error("reset");
    cover property (event_pulse);
    cover property (wr_en && !addr ##1 comparator_enable);
    cover property ($past(rd_en) && rdata[8]);
endmodule
bind acc_core acc_core_asserts acc_core_asserts_i (.clk(clk), .resetn(resetn), .wr_en(wr_en),
    .rd_en(rd_en), .event_pulse(event_pulse), .comparator_enable(comparator_enable),
    .result_output_pin(result_output_pin), .result_output_pin_oe(result_output_pin_oe),
    .addr(addr), .rdata(rdata));

// ==== tb/acc_partner.sv ====
// comparator core model: input selection and compare
module acc_partner import acc_pkg::*; (
    input wire logic plus_input_select,
    input wire acc_minus_e minus_input_select,
    input wire logic [23:0] lv,
    output logic comparator_raw
);
    timeunit 1ns;
    timeprecision 100ps;
    assign comparator_raw = (plus_input_select ? lv[7:4] : lv[3:0])
        > lv[8 + 4 * minus_input_select +: 4];
endmodule

// ==== tb/analog_comparator_control_test.sv ====
// bench for the comparator control block
module analog_comparator_control_test import acc_pkg::*;;
    timeunit 1ns;
    timeprecision 100ps;
    logic clk = 0, resetn = 0, wr_en = 0, rd_en = 0, comparator_raw, comparator_enable;
    logic plus_input_select, result_output_pin, result_output_pin_oe, event_pulse;
    logic [7:0] addr = 8'h00;
    logic [31:0] wdata = 32'h0, rdata, m = 32'hC3, s = 32'h11;
    logic [23:0] lv = 24'h0;
    acc_minus_e minus_input_select;
    int num_errors = 0, cmp_count = 0, i, evs;
    always #2.5 clk = ~clk;
    acc_core acc_core_i (.clk(clk), .resetn(resetn), .addr(addr), .wdata(wdata), .wr_en(wr_en),
        .rd_en(rd_en), .rdata(rdata), .comparator_raw(comparator_raw),
        .comparator_enable(comparator_enable), .plus_input_select(plus_input_select),
        .minus_input_select(minus_input_select), .result_output_pin(result_output_pin),
        .result_output_pin_oe(result_output_pin_oe), .event_pulse(event_pulse));
    acc_partner acc_partner_i (.plus_input_select(plus_input_select),
        .minus_input_select(minus_input_select), .lv(lv), .comparator_raw(comparator_raw));
    function logic [31:0] xs();
        s ^= s << 13;
        s ^= s >> 17;
        s ^= s << 5;
        return s;
    endfunction
    task chk(string n, logic [31:0] e, g);
        cmp_count++;
        if (g !== e) begin
            num_errors++;
            $display("ERROR %s exp %h got %h", n, e, g);
        end
    endtask
    task go(logic w, r, logic [7:0] a, logic [31:0] d);
        @(posedge clk);
        {wr_en, rd_en, addr, wdata} <= {w, r, a, d};
        if (w && !a) m = d & 32'hE0D3;
    endtask
    task rd(logic [7:0] a);
        go(0, 1, a, 0);
        go(0, 0, 0, 0);
        #1 chk("rdata", a ? 0 : m | {m[13] ^ comparator_raw, 8'h0}, rdata);
    endtask
    task tally_and_finish();
        $display("%0d checks %0d errors", cmp_count, num_errors);
        if (num_errors == 0 && cmp_count > 0) $display("All tests passed");
        else $display("Some tests failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge clk);
        resetn <= 1;
        rd(0);
        rd(4);
        repeat (12) begin
            lv <= 24'(xs());
            go(1, 0, 8, xs());
            go(1, 0, 0, xs());
            repeat (4) go(0, 0, 0, 0);
            rd(0);
            chk("ctl", {m[15:14], m[4], m[1:0], m[13] ^ comparator_raw},
                {comparator_enable, result_output_pin_oe, plus_input_select,
                minus_input_select, result_output_pin});
        end
        $display("register test done");
        for (i = 0; i < 16; i++) begin
            lv <= 0;
            go(1, 0, 0, {16'h0000, i[3], 1'h0, i[2], 5'h00, i[1:0], 6'h00});
            repeat (6) go(0, 0, 0, 0);
            evs = 0;
            lv <= 8;
            repeat (8) begin
                go(0, 0, 0, 0);
                #1 evs += int'(event_pulse);
            end
            chk("events", i[3] & (i[2] ? i[1] : i[0]), evs);
        end
        $display("event test done");
        tally_and_finish();
    end
endmodule
